// ===== design/stpio_pkg.sv
// package: register map, field layout and codes of the shift/timer parallel io engine
package stpio_pkg;
  localparam int unsigned NUM_SHIFT = 8;
  localparam int unsigned NUM_TIMER = 8;
  localparam int unsigned NUM_PIN = 32;
  localparam int unsigned ADDR_W = 12;
  // region codes taken from address bits [11:5]; index from bits [4:2]
  localparam logic [6:0] REG_GLOBAL = 7'h00;
  localparam logic [6:0] REG_SHIFT_CTL = 7'h04;
  localparam logic [6:0] REG_SHIFT_BUF = 7'h08;
  localparam logic [6:0] REG_TIMER_CTL = 7'h0c;
  localparam logic [6:0] REG_TIMER_CMP = 7'h10;
  // word index inside the global region
  localparam logic [2:0] IDX_RESOURCE = 3'h0;
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_PINS = 3'h2;
  // resource_count_register: pins, timers, shift units
  localparam logic [31:0] RESOURCE_VALUE = 32'h0020_0808;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  // shift unit control fields
  localparam int SC_MODE_LSB = 0;
  localparam int SC_TSEL_LSB = 2;
  localparam int SC_EDGE = 5;
  localparam int SC_CHAIN = 6;
  localparam int SC_PIN_OE = 7;
  localparam int SC_PSEL_LSB = 8;
  localparam int SC_PIN_POL = 13;
  localparam int SC_WIDTH_LSB = 16;
  // timer control fields
  localparam int TC_MODE_LSB = 0;
  localparam int TC_TSRC = 2;
  localparam int TC_TPOL = 3;
  localparam int TC_TSEL_LSB = 8;
  localparam int TC_DEC_LSB = 14;
  localparam int TC_PSEL_LSB = 16;
  localparam int TC_POE = 21;
  localparam int TC_PPOL = 22;
  localparam int TC_EN_LSB = 24;
  localparam int TC_DIS_LSB = 26;
  localparam int TC_RST_LSB = 28;
  // shift unit modes
  localparam logic [1:0] SM_OFF = 2'h0;
  localparam logic [1:0] SM_TX = 2'h1;
  localparam logic [1:0] SM_RX = 2'h2;
  localparam logic [1:0] SM_MATCH = 2'h3;
  // timer modes
  localparam logic [1:0] TM_OFF = 2'h0;
  localparam logic [1:0] TM_BAUD = 2'h1;
  localparam logic [1:0] TM_PWM = 2'h2;
  localparam logic [1:0] TM_SINGLE = 2'h3;
  // bus width codes
  localparam logic [2:0] W_SERIAL = 3'h0;
  localparam logic [2:0] W_4 = 3'h1;
  localparam logic [2:0] W_8 = 3'h2;
  localparam logic [2:0] W_16 = 3'h3;
  localparam logic [2:0] W_32 = 3'h4;
  // timer condition selector and bus response codes
  localparam logic [1:0] DIS_ON_CMP = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== design/stpio_top.sv
// shift/timer parallel io engine with axi4-lite register slave
// Contract
// - eight 32-bit shift units, transmit/receive/match, each behind its own buffer register.
// - transmit loads the buffer into the shift register, then shifts it to pins.
// - receive shifts from pins, then stores the result into the buffer.
// - only the selected timer loads, stores and shifts a unit; any timer selectable.
// - timers run dual 8-bit baud/bit, dual 8-bit pwm, or single 16-bit.
// - baud mode low byte divides the clock, high byte counts shift clock toggles.
// - on enable the timer loads its compare value, then counts down.
// - low byte zero toggles shift clock and output, decrements high, reloads low.
// - two low-byte periods make one shift cycle, moving the unit one beat.
// - full count at zero ends the frame and the timer disables itself.
// - transmit trigger is the inverted unit flag; buffer write clears the flag.
// - slave receive uses single 16-bit mode, pin clock and pin trigger.
// - data moves msb to lsb; serial leaves at bit 0, enters bit 31.
// - parallel mode outputs low n bits, inputs top n bits, n per shift.
// - parallel width is 4, 8, 16 or 32 bits.
// - units chain so upper units act as a queue for the pin unit.
// - only units 0 and 4 drive parallel pins; others feed the lower unit.
// - only units 3 and 7 capture parallel pins; others take from higher unit.
// - read-only register reports eight units, eight timers, thirty-two pins.
// - shift edge, pin direction, pin polarity and trigger polarity are configurable.
// - enable, decrement and reset come from trigger, pin or adjacent timer; disable from trigger or adjacent timer.
// - a load event empties the buffers and sets the unit flags.
module stpio_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [stpio_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [stpio_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [stpio_pkg::NUM_PIN-1:0] pin_in,
  output logic [stpio_pkg::NUM_PIN-1:0] pin_out,
  output logic [stpio_pkg::NUM_PIN-1:0] pin_oe
);
  import stpio_pkg::*;

  typedef enum logic [1:0] {WS_IDLE = 2'h1, WS_RESP = 2'h2} stpio_wst_t;
  typedef enum logic [1:0] {RS_IDLE = 2'h1, RS_DATA = 2'h2} stpio_rst_t;

  typedef struct packed {
    logic [7:0][31:0] sctl;
    logic [7:0][31:0] sbuf;
    logic [7:0][31:0] sreg;
    logic [7:0][31:0] tctl;
    logic [7:0][31:0] tcmp;
    logic [7:0][15:0] cnt;
    logic [7:0] flag;
    logic [7:0] en;
    logic [7:0] sclk;
    logic [7:0] tout;
    logic [7:0] tog;
    logic [7:0] trig;
    logic [31:0] pin_prev;
    logic [31:0] pout;
    logic [31:0] poe;
    logic aw_have;
    logic w_have;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    stpio_wst_t ws;
    logic [1:0] bresp;
    stpio_rst_t rs;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } stpio_state_t;

  stpio_state_t s_q;
  stpio_state_t s_d;

  logic [7:0] t_start, t_cmp, t_rise, t_fall;
  logic [31:0] c, k, src, win, nsr, mask;
  logic [15:0] cn;
  logic [2:0] adj, ts, idx;
  logic [5:0] n;
  logic trg, tp, tpp, go, stop, rld, tick, shl, par;

  // byte-lane merge for register writes
  function automatic logic [31:0] stpio_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // width code to bits per shift; unknown codes fall back to serial
  function automatic logic [5:0] stpio_width(input logic [2:0] w);
    case (w)
      W_4: return 6'h04;
      W_8: return 6'h08;
      W_16: return 6'h10;
      W_32: return 6'h20;
      default: return 6'h01;
    endcase
  endfunction

  function automatic logic [31:0] stpio_rol(input logic [31:0] v, input logic [4:0] s);
    return 32'(({v, v} << s) >> 32);
  endfunction

  function automatic logic [31:0] stpio_ror(input logic [31:0] v, input logic [4:0] s);
    return 32'({v, v} >> s);
  endfunction

  // handshakes straight from the state machines
  assign awready = (s_q.ws == WS_IDLE) && !s_q.aw_have;
  assign wready = (s_q.ws == WS_IDLE) && !s_q.w_have;
  assign bvalid = (s_q.ws == WS_RESP);
  assign bresp = s_q.bresp;
  assign arready = (s_q.rs == RS_IDLE);
  assign rvalid = (s_q.rs == RS_DATA);
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign pin_out = s_q.pout;
  assign pin_oe = s_q.poe;

  // whole next state; bus writes first so hardware flag sets win over clears
  always_comb begin
    s_d = s_q;
    {t_start, t_cmp, t_rise, t_fall} = '0;
    {c, k, src, win, nsr, mask} = '0;
    cn = '0;
    {adj, ts, idx} = '0;
    n = '0;
    {trg, tp, tpp, go, stop, rld, tick, shl, par} = '0;
    s_d.tog = '0;
    s_d.pin_prev = pin_in;
    s_d.pout = '0;
    s_d.poe = '0;

    // write address and data may come in either order
    if (awvalid && awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_d.aw_have && s_d.w_have) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.ws = WS_RESP;
      s_d.bresp = RESP_OKAY;
      idx = s_d.awaddr[4:2];
      case (s_d.awaddr[11:5])
        REG_GLOBAL: begin
          // read-only words accept and ignore writes
          if (idx > IDX_PINS) begin
            s_d.bresp = RESP_SLVERR;
          end
        end
        REG_SHIFT_CTL: s_d.sctl[idx] = stpio_merge(s_q.sctl[idx], s_d.wdata, s_d.wstrb);
        REG_SHIFT_BUF: begin
          s_d.sbuf[idx] = stpio_merge(s_q.sbuf[idx], s_d.wdata, s_d.wstrb);
          if (s_q.sctl[idx][SC_MODE_LSB +: 2] != SM_RX) begin
            s_d.flag[idx] = 1'b0;
          end
        end
        REG_TIMER_CTL: s_d.tctl[idx] = stpio_merge(s_q.tctl[idx], s_d.wdata, s_d.wstrb);
        REG_TIMER_CMP: s_d.tcmp[idx] = stpio_merge(s_q.tcmp[idx], s_d.wdata, s_d.wstrb);
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid && bready) begin
      s_d.ws = WS_IDLE;
    end

    // read decode; a receive buffer read empties it
    if (arvalid && arready) begin
      s_d.rs = RS_DATA;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      idx = araddr[4:2];
      case (araddr[11:5])
        REG_GLOBAL: begin
          if (idx == IDX_RESOURCE) begin
            s_d.rdata = RESOURCE_VALUE;
          end else if (idx == IDX_STATUS) begin
            s_d.rdata = {16'h0000, s_q.en, s_q.flag};
          end else if (idx == IDX_PINS) begin
            s_d.rdata = pin_in;
          end else begin
            s_d.rresp = RESP_SLVERR;
          end
        end
        REG_SHIFT_CTL: s_d.rdata = s_q.sctl[idx];
        REG_SHIFT_BUF: begin
          s_d.rdata = s_q.sbuf[idx];
          if (s_q.sctl[idx][SC_MODE_LSB +: 2] == SM_RX) begin
            s_d.flag[idx] = 1'b0;
          end
        end
        REG_TIMER_CTL: s_d.rdata = s_q.tctl[idx];
        REG_TIMER_CMP: s_d.rdata = s_q.tcmp[idx];
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end
    if (rvalid && rready) begin
      s_d.rs = RS_IDLE;
    end

    // timers: trigger, conditions and the countdown
    for (int t = 0; t < 8; t++) begin
      c = s_q.tctl[t];
      k = s_q.tcmp[t];
      adj = 3'(t + 1);
      trg = (c[TC_TSRC] ? pin_in[c[TC_TSEL_LSB +: 5]] : s_q.flag[c[TC_TSEL_LSB +: 3]]) ^ c[TC_TPOL];
      tp = pin_in[c[TC_PSEL_LSB +: 5]];
      tpp = s_q.pin_prev[c[TC_PSEL_LSB +: 5]];
      s_d.trig[t] = trg;
      // pin or trigger decrement counts both edges, so a pin clock gives two per period
      case (c[TC_DEC_LSB +: 2])
        2'h0: tick = 1'b1;
        2'h1: tick = tp ^ tpp;
        2'h2: tick = trg ^ s_q.trig[t];
        default: tick = s_q.tog[adj];
      endcase
      case (c[TC_EN_LSB +: 2])
        2'h0: go = 1'b1;
        2'h1: go = trg;
        2'h2: go = tp;
        default: go = s_q.en[adj];
      endcase
      case (c[TC_DIS_LSB +: 2])
        2'h2: stop = !trg;
        2'h3: stop = !s_q.en[adj];
        default: stop = 1'b0;
      endcase
      case (c[TC_RST_LSB +: 2])
        2'h1: rld = trg && !s_q.trig[t];
        2'h2: rld = tp && !tpp;
        2'h3: rld = s_q.tog[adj];
        default: rld = 1'b0;
      endcase
      t_start[t] = !s_q.en[t] && (c[TC_MODE_LSB +: 2] != TM_OFF) && go;
      if (t_start[t]) begin
        s_d.en[t] = 1'b1;
        s_d.cnt[t] = k[15:0];
        s_d.sclk[t] = 1'b0;
        s_d.tout[t] = 1'b0;
      end else if (s_q.en[t]) begin
        cn = s_q.cnt[t];
        if ((c[TC_MODE_LSB +: 2] == TM_OFF) || stop) begin
          s_d.en[t] = 1'b0;
        end else if (rld) begin
          s_d.cnt[t] = k[15:0];
        end else if (tick) begin
          case (c[TC_MODE_LSB +: 2])
            TM_SINGLE: begin
              if (cn == 16'h0000) begin
                s_d.tog[t] = 1'b1;
                s_d.cnt[t] = k[15:0];
                t_cmp[t] = 1'b1;
              end else begin
                s_d.cnt[t] = cn - 16'h0001;
              end
            end
            TM_PWM: begin
              if (cn[7:0] != 8'h00) begin
                s_d.cnt[t][7:0] = cn[7:0] - 8'h01;
              end else begin
                // high phase from the low compare byte, low phase from the high one
                s_d.tog[t] = 1'b1;
                s_d.cnt[t][7:0] = s_q.tout[t] ? k[15:8] : k[7:0];
              end
            end
            default: begin
              if (cn[7:0] != 8'h00) begin
                s_d.cnt[t][7:0] = cn[7:0] - 8'h01;
              end else begin
                s_d.tog[t] = 1'b1;
                s_d.cnt[t][7:0] = k[7:0];
                if (cn[15:8] == 8'h00) begin
                  t_cmp[t] = 1'b1;
                end else begin
                  s_d.cnt[t][15:8] = cn[15:8] - 8'h01;
                end
              end
            end
          endcase
          if (s_d.tog[t]) begin
            s_d.sclk[t] = !s_q.sclk[t];
            s_d.tout[t] = !s_q.tout[t];
          end
          if (t_cmp[t] && (c[TC_DIS_LSB +: 2] == DIS_ON_CMP)) begin
            s_d.en[t] = 1'b0;
          end
        end
      end
      // a rising then a falling toggle make one shift cycle
      t_rise[t] = s_d.tog[t] && !s_q.sclk[t];
      t_fall[t] = s_d.tog[t] && s_q.sclk[t];
    end

    // shift units, all moving on the edges of their selected timer
    for (int i = 0; i < 8; i++) begin
      c = s_q.sctl[i];
      ts = c[SC_TSEL_LSB +: 3];
      n = stpio_width(c[SC_WIDTH_LSB +: 3]);
      par = (n != 6'h01);
      // pin run starts at the selected pin; software keeps it consecutive
      win = stpio_ror(pin_in, c[SC_PSEL_LSB +: 5]) ^ {32{c[SC_PIN_POL]}};
      if (c[SC_CHAIN] && (i < 7)) begin
        src = s_q.sreg[3'(i + 1)];
      end else if (!par || (i == 3) || (i == 7)) begin
        src = win;
      end else begin
        src = '0;
      end
      shl = c[SC_EDGE] ? t_fall[ts] : t_rise[ts];
      nsr = 32'(({src, s_q.sreg[i]} >> n));
      case (c[SC_MODE_LSB +: 2])
        SM_TX: begin
          if (t_start[ts]) begin
            s_d.sreg[i] = s_q.sbuf[i];
            s_d.flag[i] = 1'b1;
          end else if (shl) begin
            s_d.sreg[i] = nsr;
          end
        end
        SM_RX: begin
          if (shl) begin
            s_d.sreg[i] = nsr;
          end
          if (t_cmp[ts]) begin
            s_d.sbuf[i] = s_d.sreg[i];
            s_d.flag[i] = 1'b1;
          end
        end
        SM_MATCH: begin
          if (shl) begin
            s_d.sreg[i] = nsr;
            if (nsr == s_q.sbuf[i]) begin
              s_d.flag[i] = 1'b1;
            end
          end
        end
        default: ;
      endcase
      // parallel drive only from units 0 and 4; serial from any unit
      if ((c[SC_MODE_LSB +: 2] == SM_TX) && c[SC_PIN_OE] && (!par || (i == 0) || (i == 4))) begin
        mask = 32'((64'h1 << n) - 64'h1);
        s_d.poe = s_d.poe | stpio_rol(mask, c[SC_PSEL_LSB +: 5]);
        s_d.pout = s_d.pout | stpio_rol((s_d.sreg[i] ^ {32{c[SC_PIN_POL]}}) & mask, c[SC_PSEL_LSB +: 5]);
      end
    end

    // timer outputs take their pin over any shifter using it
    for (int t = 0; t < 8; t++) begin
      c = s_q.tctl[t];
      if (c[TC_POE]) begin
        s_d.poe[c[TC_PSEL_LSB +: 5]] = 1'b1;
        s_d.pout[c[TC_PSEL_LSB +: 5]] = s_d.tout[t] ^ c[TC_PPOL];
      end
    end
  end

  // single state register; reset clears everything except the bus state machines, which load their idle codes
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.sctl <= {8{CTL_RESET}};
      s_q.tctl <= {8{CTL_RESET}};
      s_q.ws <= WS_IDLE;
      s_q.rs <= RS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // stpio_top

// ===== test/stpio_top_sva.sv
// checker: bus handshake, register answers and reset state of the io engine
module stpio_top_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [stpio_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [stpio_pkg::NUM_PIN-1:0] pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import stpio_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // write channel: answer, hold and blocking
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_bvalid_drops: assert property (bvalid && bready |=> !bvalid)
    else $error("write response held too long");
  a_write_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  // read channel: answer, hold, blocking, resource and unmapped reads
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed while waiting");
  a_read_blocked: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_resource_read: assert property (arvalid && arready && araddr == 12'h000
    |=> rdata == RESOURCE_VALUE && rresp == RESP_OKAY)
    else $error("resource count wrong");
  a_unmapped_read: assert property (arvalid && arready && araddr >= 12'h220
    |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  // first edge after reset leaves bus idle and pins released
  a_reset_idle: assert property ($fell(srst) |-> !bvalid && !rvalid && pin_oe == 32'h0)
    else $error("state not cleared by reset");
  c_slverr_write: cover property (bvalid && bready && bresp == RESP_SLVERR);
  c_read_done: cover property (rvalid && rready && rresp == RESP_OKAY);
  c_strobe_drive: cover property ($rose(pin_oe[8]));
endmodule // stpio_top_sva

bind stpio_top stpio_top_sva u_sva (.clk, .srst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_oe);

// ===== test/stpio_periph_model.sv
// partner: 8-bit parallel peripheral that latches writes and serves reads
module stpio_periph_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [31:0] pin_out,
  input wire logic rx_go,
  input wire logic [31:0] rx_word,
  output logic [31:0] cap_word,
  output logic [3:0] cap_count,
  output logic [7:0] rd_bus,
  output logic rd_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_q = 1'h0;
  logic rd_q = 1'h0;
  logic [1:0] idx = 2'h0;
  // write strobe on pin 8, read strobe on pin 9, select driven onto pin 24
  always @(posedge clk) begin
    wr_q <= pin_out[8];
    rd_q <= pin_out[9];
    if (srst) begin
      cap_word <= 32'h0;
      cap_count <= 4'h0;
      rd_sel <= 1'h0;
      rd_bus <= 8'h0;
    end else begin
      // bytes arrive lowest first, so they fill the word from the top
      if (pin_out[8] && !wr_q) begin
        cap_word <= {pin_out[7:0], cap_word[31:8]};
        cap_count <= cap_count + 4'h1;
      end
      if (rx_go) begin
        rd_sel <= 1'h1;
        idx <= 2'h0;
        rd_bus <= rx_word[7:0];
      end else if (rd_sel && pin_out[9] && !rd_q) begin
        idx <= idx + 2'h1;
        // drop select after the last latch, else the timer would start again
        if (idx == 2'h3) begin
          rd_sel <= 1'h0;
          rd_bus <= ~rd_bus; // released bus shows the inverse of the last byte
        end
      end else if (rd_sel && !pin_out[9] && rd_q) begin
        rd_bus <= rx_word[8 * idx +: 8]; // next byte held over the next rising strobe
      end
    end
  end
endmodule // stpio_periph_model

// ===== test/stpio_top_test.sv
// testbench: register table, parallel transmit and receive frames, reset mid-frame
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("Error %s expected %h seen %h", nm, e, g); end end
module stpio_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import stpio_pkg::*;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} stpio_row_t;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, rd_sel, rx_go = 1'h0;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, pin_in, pin_out, pin_oe, cap_word, data, st, rx_word = 32'h0;
  logic [3:0] cap_count;
  logic [7:0] rd_bus;
  int failures = 0;
  int check_count = 0;
  int i;
  stpio_row_t rows [9] = '{
    '{1'h1, 12'h000, 32'hffffffff, 32'h0, RESP_OKAY}, // read-only word ignores writes
    '{1'h1, 12'h3f0, 32'h00000001, 32'h0, RESP_SLVERR},
    '{1'h0, 12'h000, 32'h0, RESOURCE_VALUE, RESP_OKAY},
    '{1'h0, 12'h004, 32'h0, 32'h0, RESP_OKAY},
    '{1'h0, 12'h080, 32'h0, CTL_RESET, RESP_OKAY},
    '{1'h0, 12'h180, 32'h0, CTL_RESET, RESP_OKAY},
    '{1'h1, 12'h084, 32'h00021004, 32'h0, RESP_OKAY},
    '{1'h0, 12'h084, 32'h0, 32'h00021004, RESP_OKAY},
    '{1'h0, 12'h3fc, 32'h0, 32'h0, RESP_SLVERR}};
  // pins: driven levels win, the partner fills the rest
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {7'h0, rd_sel, rd_bus, 16'h0});
  always #25 clk = ~clk;
  stpio_top u_dut (.clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  stpio_periph_model u_peer (.clk(clk), .srst(srst), .pin_out(pin_out), .rx_go(rx_go), .rx_word(rx_word),
    .cap_word(cap_word), .cap_count(cap_count), .rd_bus(rd_bus), .rd_sel(rd_sel));
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ready is looked at on the falling edge, so the rising edge that takes it is known in advance
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta;
    logic tw;
    logic tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    tb = 1'h0;
    for (n = 0; n < 50 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    if (!tb) begin
      `CHK("write answer", 1'h1, tb)
      end_sim();
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta;
    logic tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    tr = 1'h0;
    for (n = 0; n < 50 && !tr; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    if (!tr) begin
      `CHK("read answer", 1'h1, tr)
      end_sim();
    end
  endtask
  task automatic wait_cap(input logic [3:0] n);
    int k;
    for (k = 0; k < 400 && cap_count !== n; k++) @(negedge clk);
    `CHK("latched bytes", n, cap_count)
    if (cap_count !== n) end_sim();
  endtask
  task automatic poll(input int b, input logic v);
    int k;
    st = {32{~v}};
    for (k = 0; k < 60 && st[b] !== v; k++) rd(12'h004, st, resp);
    `CHK("status bit", v, st[b])
    if (st[b] !== v) end_sim();
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    for (i = 0; i < 9; i++) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d, resp);
      end else begin
        rd(rows[i].a, data, resp);
        `CHK("read data", rows[i].e, data)
      end
      `CHK("response", rows[i].r, resp)
    end
    $display("test register table done");
    // transmit: unit 0, 8 bits on pins 0..7, shift on falling, strobe on pin 8, 4 beats
    wr(12'h100, 32'hc3a55a3c, resp);
    wr(12'h080, 32'h000200a1, resp);
    wr(12'h200, 32'h00000703, resp);
    wr(12'h180, 32'h05280009, resp);
    wait_cap(4'h1);
    `CHK("pin drive", 9'h1ff, pin_oe[8:0])
    wait_cap(4'h4);
    `CHK("tx word", 32'hc3a55a3c, cap_word)
    poll(8, 1'h0);
    `CHK("buffer empty", 1'h1, st[0])
    `CHK("no extra beat", 4'h4, cap_count)
    // refilling the buffer alone starts the next frame
    wr(12'h100, 32'h11223344, resp);
    wait_cap(4'h8);
    `CHK("tx word 2", 32'h11223344, cap_word)
    $display("test transmit done");
    // receive: unit 7, timer 1 strobe on pin 9, started by select on pin 24
    wr(12'h09c, 32'h00021006, resp);
    wr(12'h204, 32'h00000703, resp);
    wr(12'h184, 32'h05291805, resp);
    @(posedge clk);
    rx_word <= 32'h5aa50ff0;
    rx_go <= 1'h1;
    @(posedge clk);
    rx_go <= 1'h0;
    poll(7, 1'h1);
    rd(12'h11c, data, resp);
    `CHK("rx word", 32'h5aa50ff0, data)
    poll(7, 1'h0);
    $display("test receive done");
    // single 16-bit timer on the clock, output on pin 10: one toggle every cmp+1 cycles
    wr(12'h208, 32'h00000002, resp);
    wr(12'h188, 32'h002a0003, resp);
    repeat (4) @(negedge clk);
    data = 32'h0;
    for (i = 0; i < 12; i++) begin
      st[0] = pin_out[10];
      @(negedge clk);
      data = data + 32'(st[0] != pin_out[10]);
    end
    `CHK("single toggles", 32'h4, data)
    wr(12'h188, 32'h0, resp);
    $display("test single counter done");
    // reset in the middle of a transmit frame
    wr(12'h100, 32'h0f0f0f0f, resp);
    wait_cap(4'h9);
    @(posedge clk);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    `CHK("pins released", 32'h0, pin_oe)
    rd(12'h180, data, resp);
    `CHK("timer ctl cleared", CTL_RESET, data)
    rd(12'h100, data, resp);
    `CHK("buffer cleared", 32'h0, data)
    $display("test reset done");
    end_sim();
  end
endmodule // stpio_top_test
